/* hw/sild_driver.sv */
// serial-in shift register with transparent latches and gated sink outputs
// Notes on behaviour
// - rising serial clock captures data into the queue feeding stage one, unless the queue is full
// - stages shift toward serial output; output shows last
// - strobe high copies each stage into latch
// - latches stay transparent while strobe stays high
// - enable low turns every sink output off
// - enable changes never touch latch contents
// - enable high makes outputs follow their latches
// - thirty-two stages, latches and sink outputs
`default_nettype none
module sild_driver
   import sild_pkg::*;
#(
   parameter int STAGES     = SILD_STAGES,
   parameter int FIFO_DEPTH = SILD_FIFO_DEPTH
) (
   input  wire logic              i_sys_clk,
   input  wire logic              i_reset,
   input  wire logic              i_serial_clk,
   input  wire logic              i_serial_data,
   input  wire logic              i_strobe,
   input  wire logic              i_out_enable,
   input  wire logic              i_hold,
   output logic                   o_in_ready,
   output logic                   o_serial_out,
   output logic [STAGES-1:0]      o_sink_on
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] sclk_sync_reg;
   logic [1:0] sdi_sync_reg;
   logic [1:0] stb_sync_reg;
   logic [1:0] oe_sync_reg;
   logic       sclk_prev_reg;
   logic       sdi_prev_reg;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         sclk_sync_reg <= 2'h0;
         sdi_sync_reg  <= 2'h0;
         stb_sync_reg  <= 2'h0;
         oe_sync_reg   <= 2'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], i_serial_clk};
         sdi_sync_reg  <= {sdi_sync_reg[0], i_serial_data};
         stb_sync_reg  <= {stb_sync_reg[0], i_strobe};
         oe_sync_reg   <= {oe_sync_reg[0], i_out_enable};
      end
   end

   // data delayed one more stage so it pairs with the clock sample before the edge
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         sclk_prev_reg <= 1'b0;
         sdi_prev_reg  <= 1'b0;
      end else begin
         sclk_prev_reg <= sclk_sync_reg[1];
         sdi_prev_reg  <= sdi_sync_reg[1];
      end
   end

   logic sclk_rise;
   logic strobe_s;
   logic oe_s;

   assign sclk_rise = sclk_sync_reg[1] && !sclk_prev_reg;
   assign strobe_s  = stb_sync_reg[1];
   assign oe_s      = oe_sync_reg[1];

   // ----------------------------------------
   // captured bit queue
   // ----------------------------------------
   // absorbs bursts while i_hold pauses shifting; a bit arriving when full is lost
   logic fifo_valid;
   logic fifo_bit;
   logic shift_pop;

   assign shift_pop = fifo_valid && !i_hold;

   sild_fifo #(
      .WIDTH (1),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_reset     (i_reset),
      .i_in_valid  (sclk_rise),
      .o_in_ready  (o_in_ready),
      .i_in_data   (sdi_prev_reg),
      .o_out_valid (fifo_valid),
      .i_out_ready (!i_hold),
      .o_out_data  (fifo_bit)
   );

   // ----------------------------------------
   // shift register
   // ----------------------------------------
   logic [STAGES-1:0] shift_reg;
   logic [STAGES-1:0] latch_reg;
   logic [STAGES-1:0] sink_reg;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         shift_reg <= SILD_SHIFT_RESET[STAGES-1:0];
      end else if (shift_pop) begin
         shift_reg <= {shift_reg[STAGES-2:0], fifo_bit};
      end
   end

   assign o_serial_out = shift_reg[STAGES-1];

   // ----------------------------------------
   // latches and output gate
   // ----------------------------------------
   // strobe alone steers the latches, enable is not in this path
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         latch_reg <= SILD_LATCH_RESET[STAGES-1:0];
      end else if (strobe_s) begin
         latch_reg <= shift_reg;
      end
   end

   // registered, so a half-synced enable never reaches the sink bank
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         sink_reg <= SILD_SINK_OFF[STAGES-1:0];
      end else if (oe_s) begin
         sink_reg <= latch_reg;
      end else begin
         sink_reg <= SILD_SINK_OFF[STAGES-1:0];
      end
   end

   assign o_sink_on = sink_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   a_edge_capture: assert property (
      sclk_rise && o_in_ready |=> u_fifo.count_reg != $past(u_fifo.count_reg)
                                  || $past(shift_pop))
      else $error("serial clock edge not captured");
   a_shift_move: assert property (
      shift_pop |=> shift_reg[STAGES-1:1] == $past(shift_reg[STAGES-2:0])
                    && shift_reg[0] == $past(fifo_bit))
      else $error("shift register did not advance");
   a_serial_last: assert property (
      shift_pop |=> o_serial_out == $past(shift_reg[STAGES-2]))
      else $error("serial output not last stage");
   a_shift_hold: assert property (
      !shift_pop |=> $stable(shift_reg))
      else $error("shift register moved without edge");
   a_latch_follow: assert property (
      strobe_s ##1 strobe_s |=> latch_reg == $past(shift_reg))
      else $error("latch not transparent while strobe high");
   a_latch_take: assert property (
      $rose(strobe_s) |=> latch_reg == $past(shift_reg))
      else $error("latch missed strobe transfer");
   a_latch_keep: assert property (
      !strobe_s |=> $stable(latch_reg))
      else $error("latch changed with strobe low");
   a_enable_latch: assert property (
      !strobe_s && $changed(oe_s) |=> latch_reg == $past(latch_reg))
      else $error("enable change disturbed latch");
   a_sink_off: assert property (
      !oe_s |=> o_sink_on == SILD_SINK_OFF[STAGES-1:0])
      else $error("sink on while enable low");
   a_sink_follow: assert property (
      oe_s |=> o_sink_on == $past(latch_reg))
      else $error("sink not following latch");
   a_pin_latency: assert property (
      !i_out_enable [*4] |-> o_sink_on == SILD_SINK_OFF[STAGES-1:0])
      else $error("enable pin low did not reach sinks");

   // ----------------------------------------
   // pin-to-output latency
   // ----------------------------------------
   // four edges: two sync stages, then the register, then the sample
   a_strobe_pin: assert property (
      i_strobe [*4] |-> latch_reg == $past(shift_reg))
      else $error("strobe pin high did not open latches");
   a_enable_pin: assert property (
      i_out_enable [*4] |-> o_sink_on == $past(latch_reg))
      else $error("enable pin high did not show latches");
   a_latch_oe_free: assert property (
      strobe_s && $changed(oe_s) |=> latch_reg == $past(shift_reg))
      else $error("enable change stopped transparent latch");

   // ----------------------------------------
   // idle, pause and refusal
   // ----------------------------------------
   a_serial_hold: assert property (
      !shift_pop |=> $stable(o_serial_out))
      else $error("serial output moved without edge");
   // paused bits wait in the queue, never in the stages
   a_hold_pause: assert property (
      i_hold |=> $stable(shift_reg))
      else $error("shift register moved during hold");
   // a refused edge is lost, it must not take a queue slot
   a_refuse_drop: assert property (
      sclk_rise && !o_in_ready |=> $stable(u_fifo.wr_ptr_reg))
      else $error("refused edge entered the queue");
   a_ready_refill: assert property (
      !o_in_ready && shift_pop |=> o_in_ready)
      else $error("queue stayed full after a shift");

   // ----------------------------------------
   // reset state
   // ----------------------------------------
   // nothing defines a power-up state, so everything but the queue storage clears to off
   a_reset_clear: assert property (
      $past(i_reset) |-> o_sink_on == SILD_SINK_OFF[STAGES-1:0]
                         && latch_reg == SILD_LATCH_RESET[STAGES-1:0]
                         && !o_serial_out && o_in_ready)
      else $error("state not cleared by reset");
endmodule
`default_nettype wire

/* hw/sild_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
`default_nettype none
module sild_fifo
   import sild_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = SILD_FIFO_DEPTH
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_reset,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (count_reg != '0);
   assign o_out_data  = mem_reg[rd_ptr_reg];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= i_in_data;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* hw/sild_pkg.sv */
// constants shared by the serial-in latched driver logic
`default_nettype none
package sild_pkg;
   localparam int          SILD_STAGES          = 32;
   localparam int          SILD_FIFO_DEPTH      = 8;
   localparam int          SILD_CLK_PERIOD_NS   = 5;
   // least gap from last serial clock edge to strobe, kept by the host
   localparam int          SILD_STROBE_SETUP_NS = 100;
   localparam int          SILD_STROBE_SETUP_CYC =
      (SILD_STROBE_SETUP_NS + SILD_CLK_PERIOD_NS - 1) / SILD_CLK_PERIOD_NS;
   localparam logic [31:0] SILD_SHIFT_RESET     = 32'h0000_0000;
   localparam logic [31:0] SILD_LATCH_RESET     = 32'h0000_0000;
   localparam logic [31:0] SILD_SINK_OFF        = 32'h0000_0000;
endpackage
`default_nettype wire

/* verif/sild_host_model.sv */
// host-side model driving the serial, strobe and enable pins
`default_nettype none
module sild_host_model (
   input  wire logic i_sys_clk,
   output logic      o_serial_clk,
   output logic      o_serial_data,
   output logic      o_strobe,
   output logic      o_out_enable
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_serial_clk  = 1'b0;
      o_serial_data = 1'b0;
      o_strobe      = 1'b0;
      o_out_enable  = 1'b0;
   end

   // ----------------------------------------
   // pin tasks
   // ----------------------------------------
   // msb of the n-bit field goes first; clock idles low between frames
   task automatic send_bits(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge i_sys_clk) o_serial_data <= w[i];
         repeat (5) @(posedge i_sys_clk);
         o_serial_clk <= 1'b1;
         repeat (5) @(posedge i_sys_clk);
         o_serial_clk  <= 1'b0;
         // released line shows the inverse, not a stale bit
         o_serial_data <= ~w[i];
         repeat (4) @(posedge i_sys_clk);
      end
   endtask

   task automatic set_strobe(input logic v);
      repeat (20) @(posedge i_sys_clk);
      o_strobe <= v;
      repeat (8) @(posedge i_sys_clk);
   endtask

   task automatic set_oe(input logic v);
      @(posedge i_sys_clk) o_out_enable <= v;
      repeat (6) @(posedge i_sys_clk);
   endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the serial-in latched driver
`default_nettype none
module testbench;
   import sild_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        i_sys_clk = 1'b0;
   logic        i_reset   = 1'b1;
   logic        i_hold    = 1'b0;
   logic        ser_clk, ser_data, strobe, oe;
   logic        o_in_ready, o_serial_out;
   logic [31:0] o_sink_on, exp_shift, word_a;
   int          err_total  = 0;
   int          n_compared = 0;

   always #2.5 i_sys_clk = ~i_sys_clk;

   sild_host_model host (.i_sys_clk(i_sys_clk), .o_serial_clk(ser_clk),
      .o_serial_data(ser_data), .o_strobe(strobe), .o_out_enable(oe));

   sild_driver dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_serial_clk(ser_clk),
      .i_serial_data(ser_data), .i_strobe(strobe), .i_out_enable(oe), .i_hold(i_hold),
      .o_in_ready(o_in_ready), .o_serial_out(o_serial_out), .o_sink_on(o_sink_on));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      #1;
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic shift(input logic [31:0] w, input int n);
      host.send_bits(w, n);
      exp_shift = (exp_shift << n) | (w & ((32'h1 << n) - 32'h1));
   endtask

   task automatic pulse_strobe();
      host.set_strobe(1'b1);
      host.set_strobe(1'b0);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic s_load();
      host.set_oe(1'b1);
      shift(word_a, 32);
      pulse_strobe();
      check(o_sink_on, word_a);
      check({31'h0, o_serial_out}, {31'h0, word_a[31]});
   endtask

   task automatic s_enable();
      host.set_oe(1'b0);
      check(o_sink_on, SILD_SINK_OFF);
      host.set_oe(1'b1);
      check(o_sink_on, word_a);
   endtask

   // fifo fills under hold, refuses the ninth edge, then drains
   task automatic s_hold();
      @(posedge i_sys_clk) i_hold <= 1'b1;
      host.send_bits(32'h0000_00DA, 8);
      check({31'h0, o_in_ready}, 32'h0);
      host.send_bits(32'h0000_0001, 1);
      check(o_sink_on, word_a);
      @(posedge i_sys_clk) i_hold <= 1'b0;
      for (int i = 0; i <= 50 && o_in_ready !== 1'b1; i++) begin
         if (i == 50) begin
            err_total++;
            stop_test();
         end
         @(posedge i_sys_clk);
      end
      repeat (12) @(posedge i_sys_clk);
      exp_shift = {exp_shift[23:0], 8'hDA};
      pulse_strobe();
      check(o_sink_on, exp_shift);
      check({31'h0, o_serial_out}, {31'h0, exp_shift[31]});
   endtask

   task automatic s_transparent();
      logic [31:0] held;
      host.set_oe(1'b0);
      host.set_strobe(1'b1);
      shift(32'h0000_0005, 3);
      check(o_sink_on, SILD_SINK_OFF);
      host.set_oe(1'b1);
      check(o_sink_on, exp_shift);
      held = exp_shift;
      host.set_strobe(1'b0);
      shift(32'h0000_0001, 1);
      repeat (8) @(posedge i_sys_clk);
      check(o_sink_on, held);
      check({31'h0, o_serial_out}, {31'h0, exp_shift[31]});
   endtask

   // mid-run reset clears stages, latches, sinks and the queue
   task automatic s_reset();
      @(posedge i_sys_clk) i_reset <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      exp_shift = SILD_SHIFT_RESET;
      check(o_sink_on, SILD_SINK_OFF);
      check({31'h0, o_serial_out}, {31'h0, exp_shift[31]});
      check({31'h0, o_in_ready}, 32'h1);
   endtask

   initial begin
      exp_shift = SILD_SHIFT_RESET;
      word_a    = 32'hA5C3_0F96;
      repeat (8) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      check(o_sink_on, SILD_SINK_OFF);
      s_load();
      s_enable();
      s_hold();
      s_transparent();
      s_reset();
      stop_test();
   end
endmodule
`default_nettype wire
